// ===== common/pin_out_select_pkg.sv
// Package for the remappable pin output select block
package pin_out_select_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int unsigned NUM_REGS = 8;
    localparam int unsigned NUM_PINS = 16;
    localparam int unsigned FIRST_PIN = 8;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned NUM_FUNCS = 32;
    localparam int unsigned REG_W = 16;

    // ----------------------------------------
    // Register map, byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_SEL_8_9 = 8'h00;
    localparam logic [7:0] ADDR_SEL_10_11 = 8'h04;
    localparam logic [7:0] ADDR_SEL_12_13 = 8'h08;
    localparam logic [7:0] ADDR_SEL_14_15 = 8'h0c;
    localparam logic [7:0] ADDR_SEL_16_17 = 8'h10;
    localparam logic [7:0] ADDR_SEL_18_19 = 8'h14;
    localparam logic [7:0] ADDR_SEL_20_21 = 8'h18;
    localparam logic [7:0] ADDR_SEL_22_23 = 8'h1c;
    localparam logic [7:0] ADDR_LAST = 8'h1c;

    // ----------------------------------------
    // Field layout and reset
    // ----------------------------------------
    localparam int unsigned EVEN_LSB = 0;
    localparam int unsigned ODD_LSB = 8;
    localparam logic [15:0] IMPL_MASK = 16'h1f1f;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [4:0] SEL_NONE = 5'h00;

    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin drive result
    typedef struct packed {
        logic [NUM_PINS-1:0] data;
        logic [NUM_PINS-1:0] enable;
    } pin_drive_t;

    // Write channel state
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_t;

endpackage

// ===== src/pin_out_select.sv
// Output select registers and routing mux for remappable pins 8 to 23
//
// Behaviour
// - Bits 12-8 of each register hold a writable selector for the odd pin of its pair.
// - Bits 4-0 of each register hold a writable selector for the even pin of its pair.
// - Bits 15-13 read zero and writes to them have no effect.
// - Bits 7-5 read zero and writes to them are ignored.
// - Every selector clears to zero at reset, so each register reads all zeros.
`timescale 1ns/100ps
`default_nettype none

module pin_out_select (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, unused
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, unused
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [pin_out_select_pkg::NUM_FUNCS-1:0] periph_out, // Peripheral outputs
    output pin_out_select_pkg::pin_drive_t pin_drive // Per pin data and enable
);
    import pin_out_select_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [REG_W-1:0] sel_q [NUM_REGS];
    logic [REG_W-1:0] sel_d [NUM_REGS];
    wr_state_t wr_q, wr_d;
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    pin_drive_t drive_q, drive_d;
    logic [SEL_W-1:0] pin_sel [NUM_PINS];
    logic [2:0] wr_idx, rd_idx;
    logic wr_hit, rd_hit;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic arready_q, arready_d;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Held write address to register index, misaligned or unmapped misses
    always_comb begin
        wr_idx = 3'h0;
        wr_hit = 1'b1;
        case (awaddr_q)
            ADDR_SEL_8_9: begin
                wr_idx = 3'h0;
            end
            ADDR_SEL_10_11: begin
                wr_idx = 3'h1;
            end
            ADDR_SEL_12_13: begin
                wr_idx = 3'h2;
            end
            ADDR_SEL_14_15: begin
                wr_idx = 3'h3;
            end
            ADDR_SEL_16_17: begin
                wr_idx = 3'h4;
            end
            ADDR_SEL_18_19: begin
                wr_idx = 3'h5;
            end
            ADDR_SEL_20_21: begin
                wr_idx = 3'h6;
            end
            ADDR_SEL_22_23: begin
                wr_idx = 3'h7;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // Read address to register index, misaligned or unmapped misses
    always_comb begin
        rd_idx = 3'h0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_SEL_8_9: begin
                rd_idx = 3'h0;
            end
            ADDR_SEL_10_11: begin
                rd_idx = 3'h1;
            end
            ADDR_SEL_12_13: begin
                rd_idx = 3'h2;
            end
            ADDR_SEL_14_15: begin
                rd_idx = 3'h3;
            end
            ADDR_SEL_16_17: begin
                rd_idx = 3'h4;
            end
            ADDR_SEL_18_19: begin
                rd_idx = 3'h5;
            end
            ADDR_SEL_20_21: begin
                rd_idx = 3'h6;
            end
            ADDR_SEL_22_23: begin
                rd_idx = 3'h7;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Write channel
    // ----------------------------------------

    // Write channel: capture address and data in any order, then respond
    always_comb begin
        wr_d = wr_q;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bresp_d = bresp_q;
        for (int i = 0; i < NUM_REGS; i++) begin
            sel_d[i] = sel_q[i];
        end
        case (wr_q)
            WR_IDLE: begin
                if (s_axi_awvalid && !aw_have_q) begin
                    aw_have_d = 1'b1;
                    awaddr_d = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_have_q) begin
                    w_have_d = 1'b1;
                    wdata_d = s_axi_wdata;
                    wstrb_d = s_axi_wstrb;
                end
                // Commit only with both halves held, so arrival order is free
                if (aw_have_q && w_have_q) begin
                    if (wr_hit) begin
                        // Only implemented bits take the write
                        if (wstrb_q[0]) begin
                            sel_d[wr_idx][7:0] = wdata_q[7:0] & IMPL_MASK[7:0];
                        end
                        if (wstrb_q[1]) begin
                            sel_d[wr_idx][15:8] = wdata_q[15:8] & IMPL_MASK[15:8];
                        end
                        bresp_d = RESP_OKAY;
                    end else begin
                        bresp_d = RESP_SLVERR;
                    end
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    wr_d = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wr_d = WR_IDLE;
                end
            end
            default: begin
                wr_d = WR_IDLE;
            end
        endcase
        // Handshake flags follow the next state so they leave a flop
        awready_d = (wr_d == WR_IDLE) && !aw_have_d;
        wready_d = (wr_d == WR_IDLE) && !w_have_d;
        bvalid_d = (wr_d == WR_RESP);
    end

    // Write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= WR_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            for (int i = 0; i < NUM_REGS; i++) begin
                sel_q[i] <= REG_RESET;
            end
        end else begin
            wr_q <= wr_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bresp_q <= bresp_d;
            for (int i = 0; i < NUM_REGS; i++) begin
                sel_q[i] <= sel_d[i];
            end
        end
    end

    // Write side outputs straight from their flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ----------------------------------------
    // Read channel
    // ----------------------------------------

    // Read channel: one read at a time, data one cycle after the address
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q) begin
            if (s_axi_rready) begin
                rvalid_d = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            rvalid_d = 1'b1;
            if (rd_hit) begin
                rdata_d = {16'h0000, sel_q[rd_idx] & IMPL_MASK};
                rresp_d = RESP_OKAY;
            end else begin
                rdata_d = 32'h0000_0000;
                rresp_d = RESP_SLVERR;
            end
        end
        // Address channel opens again once the answer is gone
        arready_d = !rvalid_d;
    end

    // Read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            arready_q <= 1'b1;
        end else begin
            rvalid_q <= rvalid_d;
            arready_q <= arready_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Read side outputs straight from their flops
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ----------------------------------------
    // Per pin function mux
    // ----------------------------------------
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        if (p % 2 == 0) begin : g_even
            assign pin_sel[p] = sel_q[p/2][EVEN_LSB +: SEL_W];
        end else begin : g_odd
            assign pin_sel[p] = sel_q[p/2][ODD_LSB +: SEL_W];
        end
        // Zero releases the pin to port logic and keeps its data low
        assign drive_d.enable[p] = (pin_sel[p] != SEL_NONE);
        assign drive_d.data[p] = (pin_sel[p] != SEL_NONE) && periph_out[pin_sel[p]];
    end

    // Registered pin drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign pin_drive = drive_q;

endmodule

`default_nettype wire

// ===== test/pin_out_select_asserts.sv
// Checker for the pin output select block
`timescale 1ns/100ps
`default_nettype none
module pin_out_select_asserts (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, low
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [31:0] periph_out, // Peripheral outputs
    input wire pin_out_select_pkg::pin_drive_t pin_drive // Pin drive
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:13] == '0)
        else $error("upper read bits not zero");
    chk_gap_zero: assert property (s_axi_rvalid |-> s_axi_rdata[7:5] == 3'h0)
        else $error("gap read bits not zero");
    chk_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
        pin_drive == '0 && !s_axi_bvalid && !s_axi_rvalid) else $error("reset did not clear");
    chk_ready_drop: assert property (s_axi_awvalid && s_axi_awready |=>
        !s_axi_awready) else $error("write address accepted twice");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    chk_idle_pins: assert property ((periph_out == '0) [*2] |->
        pin_drive.data == '0) else $error("pin data without source");
    chk_off_quiet: assert property ((pin_drive.data & ~pin_drive.enable) == '0)
        else $error("released pin carries data");
    // Main scenarios reached
    cover property (s_axi_rvalid && s_axi_rdata[12:8] != 5'h0);
    cover property (pin_drive.enable == 16'hffff);
    cover property (s_axi_bvalid);
endmodule
bind pin_out_select pin_out_select_asserts chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .periph_out,
    .pin_drive);
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the pin output select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    import pin_out_select_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, periph_out = '0;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] d;
    pin_drive_t pin_drive;
    logic [4:0] sel [16] = '{default: 5'h0};
    int n_fail = 0, tests_run = 0;
    // Clock and device
    always #2 aclk = ~aclk;
    pin_out_select DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .periph_out(periph_out), .pin_drive(pin_drive));
    // Bus write, holds each channel until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic aw, w, b;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            #3;
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) break;
        end
        `CHK(b, 1'b1)
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    // Bus read
    task automatic rd(input logic [7:0] a);
        logic ar, v;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            #3;
            ar = arvalid && arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            if (v) break;
        end
        `CHK(v, 1'b1)
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic chk_reg(input int i, input logic [15:0] e);
        rd(8'(4 * i));
        `CHK(d, {16'h0, e})
        `CHK(r, RESP_OKAY)
    endtask
    // Pins follow selectors after the data settles
    task automatic chk_pins();
        repeat (2) @(posedge aclk);
        #1;
        for (int k = 0; k < 16; k++) begin
            `CHK(pin_drive.enable[k], sel[k] != 5'h0)
            `CHK(pin_drive.data[k], (sel[k] != 5'h0) && periph_out[sel[k]])
        end
        @(posedge aclk);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 8; i++) chk_reg(i, 16'h0);
        chk_pins();
    endtask
    task automatic t_fields();
        for (int i = 0; i < 8; i++) begin
            sel[2 * i] = 5'(2 * i + 1);
            sel[2 * i + 1] = 5'(31 - 2 * i);
            wr(8'(4 * i), {16'hffff, 3'h7, sel[2 * i + 1], 3'h7, sel[2 * i]}, 4'hf);
            `CHK(r, RESP_OKAY)
            chk_reg(i, {3'h0, sel[2*i+1], 3'h0, sel[2*i]});
        end
        periph_out <= 32'h8e3c_5a96;
        chk_pins();
        periph_out <= 32'h71c3_a569;
        chk_pins();
    endtask
    task automatic t_strobe_bad();
        wr(ADDR_SEL_8_9, 32'h0, 4'h1);
        wr(ADDR_SEL_8_9, 32'h0, 4'hc);
        wr(ADDR_SEL_8_9, 32'h0000_0b1f, 4'h2);
        sel[0] = 5'h0;
        sel[1] = 5'h0b;
        chk_reg(0, {3'h0, sel[1], 3'h0, sel[0]});
        wr(8'h20, 32'h1f1f, 4'hf);
        `CHK(r, RESP_SLVERR)
        wr(8'h02, 32'h1f1f, 4'hf);
        `CHK(r, RESP_SLVERR)
        rd(8'h20);
        `CHK(d, 32'h0)
        `CHK(r, RESP_SLVERR)
        chk_reg(0, {3'h0, sel[1], 3'h0, sel[0]});
        chk_pins();
    endtask
    task automatic t_midreset();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        sel = '{default: 5'h0};
        @(posedge aclk);
        for (int i = 0; i < 8; i++) chk_reg(i, 16'h0);
        chk_pins();
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_fields();
        t_strobe_bad();
        t_midreset();
        give_verdict();
    end
    initial begin
        #40000;
        n_fail++;
        give_verdict();
    end
endmodule
`default_nettype wire
